/* hw/operating_mode_controller.v */
// operating-mode state machine with serial control port and wake-up handling
`timescale 1ns/1ns
`include "opmode_regs.vh"


module operating_mode_controller (
   // clock and reset
   input wire core_clk,
   input wire arst_n,
   // serial control port pins
   input wire portSelect_n,
   input wire portClk,
   input wire serial_data_in,
   // wake and monitor inputs from pins and the transceiver
   input wire linWakeDetect,
   input wire linBusRx,
   input wire monPin,
   input wire ldoCurrentLow,
   // watchdog expiry, same clock domain
   input wire wdExpired,
   // mode state and status
   output wire [`ST_W-1:0] modeState,
   output reg linSleepMode_q,
   output reg busWakeFlag_q,
   output reg deviceReset_q,
   output reg wdLongOpen_q,
   // supply and watchdog control
   output reg regulatorEn_q,
   output reg watchdogEn_q,
   output reg oscKeepOn_q,
   output reg serialPortEn_q,
   // switches and pins
   output reg wakePinEn_q,
   output reg supplyOutEn_q,
   output reg lowSide1En_q,
   output reg lowSide2En_q,
   output reg highSideLedEn_q,
   output reg measEn_q,
   output reg vrefEn_q,
   output reg voltMonEn_q,
   // LIN transceiver control
   output reg linTxEn_q,
   output reg linRxEn_q,
   output reg linPullupEn_q,
   output reg linWakeArmed_q,
   output reg rxdOut_q
);

   // map a mode-select code onto a state; unknown codes give no state
   function [`ST_W-1:0] modeFromCode;
      input [2:0] code;
      begin
         case (code)
            `MS_ACTIVE: modeFromCode = `ST_ACTIVE;
            `MS_RXONLY: modeFromCode = `ST_RXONLY;
            `MS_STOP: modeFromCode = `ST_STOP;
            `MS_SLEEP: modeFromCode = `ST_SLEEP;
            default: modeFromCode = `ST_NONE;
         endcase
      end
   endfunction

   // ==================================================================
   // input synchronisers
   wire [`SYNC_W-1:0] rawIn;
   reg [`SYNC_W-1:0] syncA_q;
   reg [`SYNC_W-1:0] syncB_q;
   assign rawIn = {ldoCurrentLow, monPin, linBusRx, linWakeDetect, serial_data_in,
                   portClk, portSelect_n};

   // every pin input passes two flops before any logic sees it; each flop
   // resets to its pin's idle level so release never shows a false wake
   localparam [`SYNC_W-1:0] syncRst = `SYNC_RST;
   genvar gi;
   generate
      for (gi = 0; gi < `SYNC_W; gi = gi + 1) begin : gSync
         always @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               syncA_q[gi] <= syncRst[gi];
               syncB_q[gi] <= syncRst[gi];
            end else begin
               syncA_q[gi] <= rawIn[gi];
               syncB_q[gi] <= syncA_q[gi];
            end
         end
      end
   endgenerate

   wire selN = syncB_q[0];
   wire sclk = syncB_q[1];
   wire sdi = syncB_q[2];
   wire linWakeS = syncB_q[3];
   wire linRxS = syncB_q[4];
   wire monS = syncB_q[5];
   wire curLowS = syncB_q[6];

   // ==================================================================
   // serial control port
   reg sclkDly_q;
   reg selDly_q;
   reg monDly_q;
   reg [`CW_WIDTH-1:0] shift_q;
   reg [`CW_CNT_W-1:0] bitCnt_q;
   reg [`CW_WIDTH-1:0] ctrlWord_q;
   reg cmdValid_q;

   wire sclkFall = sclkDly_q & ~sclk;
   wire selRise = ~selDly_q & selN;

   // bits arrive lsb first on the falling edge; a frame shorter than 16 bits is dropped
   // and a longer one keeps its last 16 bits, so a short transfer can never change the mode
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclkDly_q <= 1'b0;
         selDly_q <= 1'b1;
         monDly_q <= 1'b0;
         shift_q <= `RST_WORD;
         bitCnt_q <= {`CW_CNT_W{1'b0}};
         ctrlWord_q <= `RST_WORD;
         cmdValid_q <= 1'b0;
      end else begin
         sclkDly_q <= sclk;
         selDly_q <= selN;
         monDly_q <= monS;
         cmdValid_q <= 1'b0;
         if (selN) begin
            bitCnt_q <= {`CW_CNT_W{1'b0}};
         end else if (sclkFall) begin
            shift_q <= {sdi, shift_q[`CW_WIDTH-1:1]};
            if (bitCnt_q != `CW_BITS) begin
               bitCnt_q <= bitCnt_q + 1'b1;
            end
         end
         // the port is unpowered in sleep, so words are ignored there
         if (selRise && bitCnt_q == `CW_BITS && serialPortEn_q) begin
            ctrlWord_q <= shift_q;
            cmdValid_q <= 1'b1;
         end
      end
   end

   // ==================================================================
   // mode state machine
   reg [`ST_W-1:0] state_q;
   reg [`ST_W-1:0] state_d;
   reg linSleep_d;
   reg wakeEvent;
   reg wakeLow_q;
   reg wakeLow_d;
   reg busWake_d;
   wire [`ST_W-1:0] cmdMode;
   wire linArmed;
   wire monChange;

   assign modeState = state_q;
   assign cmdMode = modeFromCode({ctrlWord_q[`CW_MS2], ctrlWord_q[`CW_MS1],
                                  ctrlWord_q[`CW_MS0]});
   assign monChange = (monS != monDly_q) & wakePinEn_q;
   assign linArmed = (state_q == `ST_STANDBY) | (state_q == `ST_STOP) |
                     (state_q == `ST_SLEEP) |
                     ((state_q == `ST_ACTIVE) & linSleepMode_q);

   // next mode; wake events in the saving modes fall back to standby
   always @* begin
      state_d = state_q;
      linSleep_d = linSleepMode_q;
      wakeLow_d = wakeLow_q;
      busWake_d = busWakeFlag_q;
      wakeEvent = 1'b0;
      case (state_q)
         `ST_STANDBY, `ST_ACTIVE, `ST_RXONLY: begin
            // standby has no code, so it can only be left, not chosen
            if (cmdValid_q && cmdMode != `ST_NONE) begin
               state_d = cmdMode;
            end
         end
         `ST_STOP: begin
            if (monChange || (linArmed && linWakeS)) begin
               state_d = `ST_STANDBY;
               wakeEvent = 1'b1;
            end else if (cmdValid_q && cmdMode != `ST_NONE) begin
               state_d = cmdMode;
            end
         end
         `ST_SLEEP: begin
            if (monChange || linWakeS || wdExpired) begin
               state_d = `ST_STANDBY;
               wakeEvent = 1'b1;
            end
         end
         default: state_d = `ST_STANDBY;
      endcase
      if (cmdValid_q) begin
         linSleep_d = ctrlWord_q[`CW_LINSLEEP];
         busWake_d = 1'b0;
      end
      // a mode change other than a wake releases the receive line before a new wake grabs it
      if (state_d != state_q && !wakeEvent) begin
         wakeLow_d = 1'b0;
      end
      if (linArmed && linWakeS) begin
         wakeLow_d = 1'b1;
         busWake_d = 1'b1;
      end
   end

   // ==================================================================
   // state and inherited enables
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= `ST_STANDBY;
         linSleepMode_q <= 1'b0;
         wakeLow_q <= 1'b0;
         busWakeFlag_q <= 1'b0;
         wakePinEn_q <= 1'b0;
         supplyOutEn_q <= 1'b0;
         deviceReset_q <= 1'b0;
         wdLongOpen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         linSleepMode_q <= linSleep_d;
         wakeLow_q <= wakeLow_d;
         busWakeFlag_q <= busWake_d;
         // only active steers these; every other mode keeps what it had
         if (state_q == `ST_ACTIVE && cmdValid_q) begin
            wakePinEn_q <= ctrlWord_q[`CW_WAKEPIN];
            supplyOutEn_q <= ctrlWord_q[`CW_SUPPLY];
         end
         deviceReset_q <= (state_q == `ST_SLEEP) & wdExpired;
         wdLongOpen_q <= wakeEvent & ~ctrlWord_q[`CW_WDON];
      end
   end

   // ==================================================================
   // per-mode gating, registered one cycle behind the state
   wire inActive = (state_q == `ST_ACTIVE);
   wire inRxOnly = (state_q == `ST_RXONLY);
   wire inStop = (state_q == `ST_STOP);
   wire inSleep = (state_q == `ST_SLEEP);
   wire wdOn = ctrlWord_q[`CW_WDON];
   wire linUp = inActive & ~linSleepMode_q;

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         regulatorEn_q <= 1'b1;
         watchdogEn_q <= 1'b1;
         oscKeepOn_q <= 1'b1;
         serialPortEn_q <= 1'b1;
         lowSide1En_q <= 1'b0;
         lowSide2En_q <= 1'b0;
         highSideLedEn_q <= 1'b0;
         measEn_q <= 1'b0;
         vrefEn_q <= 1'b0;
         voltMonEn_q <= 1'b0;
         linTxEn_q <= 1'b0;
         linRxEn_q <= 1'b0;
         linPullupEn_q <= 1'b0;
         linWakeArmed_q <= 1'b1;
         rxdOut_q <= 1'b1;
      end else begin
         regulatorEn_q <= ~inSleep;
         // in stop the load current also gates the dog off
         if (inStop) begin
            watchdogEn_q <= wdOn & ~curLowS;
         end else if (inSleep) begin
            watchdogEn_q <= wdOn;
         end else begin
            watchdogEn_q <= 1'b1;
         end
         oscKeepOn_q <= ~inSleep | wdOn;
         serialPortEn_q <= ~inSleep;
         // switches stay off outside active, sleep included
         lowSide1En_q <= inActive & ctrlWord_q[`CW_LS1];
         lowSide2En_q <= inActive & ctrlWord_q[`CW_LS2];
         highSideLedEn_q <= inActive & ctrlWord_q[`CW_HSLED];
         measEn_q <= inActive & ctrlWord_q[`CW_MEAS];
         vrefEn_q <= inActive;
         voltMonEn_q <= inActive;
         linTxEn_q <= linUp;
         linRxEn_q <= linUp | inRxOnly;
         linPullupEn_q <= linUp | inRxOnly;
         linWakeArmed_q <= linArmed;
         // bus level only where the receiver runs, else the wake line
         if (linUp || inRxOnly) begin
            rxdOut_q <= linRxS & ~wakeLow_q;
         end else begin
            rxdOut_q <= ~wakeLow_q;
         end
      end
   end

endmodule

/* hw/opmode_regs.vh */
// constants of the operating-mode controller: word layout, mode codes, state codes
`ifndef OPMODE_REGS_VH
`define OPMODE_REGS_VH

// ==================================================================
// serial control word
`define CW_WIDTH 16
`define CW_CNT_W 5
`define CW_BITS 5'h10
`define CW_MS0 0
`define CW_MS1 1
`define CW_MS2 2
`define CW_LINSLEEP 3
`define CW_WDON 4
`define CW_WAKEPIN 5
`define CW_SUPPLY 6
`define CW_LS1 7
`define CW_LS2 8
`define CW_HSLED 9
`define CW_MEAS 10

// ==================================================================
// mode-select codes
`define MS_ACTIVE 3'h1
`define MS_RXONLY 3'h2
`define MS_STOP 3'h3
`define MS_SLEEP 3'h4

// ==================================================================
// one-hot mode states
`define ST_W 5
`define ST_STANDBY 5'h01
`define ST_ACTIVE 5'h02
`define ST_RXONLY 5'h04
`define ST_STOP 5'h08
`define ST_SLEEP 5'h10
`define ST_NONE 5'h00

// ==================================================================
// reset values and synchroniser layout
`define RST_WORD 16'h0000
`define SYNC_W 7
// idle level of each synchronised pin: select high, bus recessive, the rest low
`define SYNC_RST 7'h11

`endif

/* tb/opmode_properties.sv */
// concurrent checks on the ports of the operating-mode controller
`timescale 1ns/1ns
`include "opmode_regs.vh"
module opmode_properties (
   // clock and reset
   input wire core_clk,
   input wire arst_n,
   // watched inputs
   input wire linWakeDetect,
   input wire ldoCurrentLow,
   input wire wdExpired,
   // watched outputs
   input wire [`ST_W-1:0] modeState,
   input wire linSleepMode_q,
   input wire deviceReset_q,
   input wire regulatorEn_q,
   input wire watchdogEn_q,
   input wire lowSide1En_q,
   input wire linTxEn_q,
   input wire linRxEn_q,
   input wire linPullupEn_q,
   input wire linWakeArmed_q,
   input wire rxdOut_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // ==========================================
   // gating follows the mode one cycle late, so the gating checks wait two cycles, the stop watchdog check five
   mode_onehot_a: assert property ($onehot(modeState)) else $error("mode not one-hot");
   active_lin_a: assert property ((modeState == `ST_ACTIVE && !linSleepMode_q)[*2] |->
      linTxEn_q && linRxEn_q && !linWakeArmed_q) else $error("active lin gating");
   lin_sleep_a: assert property ((modeState == `ST_ACTIVE && linSleepMode_q)[*2] |->
      !linTxEn_q && !linRxEn_q && !linPullupEn_q && linWakeArmed_q) else $error("lin sleep");
   rx_only_a: assert property ((modeState == `ST_RXONLY)[*2] |-> !linTxEn_q && linRxEn_q)
      else $error("rx-only gating");
   sleep_off_a: assert property ((modeState == `ST_SLEEP)[*2] |->
      !regulatorEn_q && !linTxEn_q && !linRxEn_q && !lowSide1En_q) else $error("sleep gating");
   wake_armed_a: assert property ((modeState inside {`ST_STANDBY, `ST_STOP, `ST_SLEEP})[*2]
      |-> linWakeArmed_q) else $error("wake not armed");
   wd_expiry_a: assert property (modeState == `ST_SLEEP && wdExpired |=>
      modeState == `ST_STANDBY && deviceReset_q) else $error("expiry in sleep");
   sleep_wake_a: assert property (modeState == `ST_SLEEP && $rose(linWakeDetect) |->
      ##[1:6] modeState == `ST_STANDBY) else $error("lin wake from sleep");
   rxd_hold_a: assert property (!rxdOut_q && modeState == `ST_STANDBY && $stable(modeState)
      |=> !rxdOut_q) else $error("receive line released");
   stop_wd_a: assert property ((modeState == `ST_STOP && ldoCurrentLow)[*5] |-> !watchdogEn_q)
      else $error("watchdog on at low current");
   // main scenarios
   cover property (modeState == `ST_SLEEP ##1 modeState == `ST_STANDBY);
   cover property (modeState == `ST_ACTIVE && linSleepMode_q);
   cover property (modeState == `ST_STOP && ldoCurrentLow);
endmodule
bind operating_mode_controller opmode_properties opmode_properties_inst (.core_clk, .arst_n,
   .linWakeDetect, .ldoCurrentLow, .wdExpired, .modeState, .linSleepMode_q, .deviceReset_q,
   .regulatorEn_q, .watchdogEn_q, .lowSide1En_q, .linTxEn_q, .linRxEn_q, .linPullupEn_q,
   .linWakeArmed_q, .rxdOut_q);

/* tb/mcu_serial_model.sv */
// serial control port master standing in for the companion microcontroller
`timescale 1ns/1ns
module mcu_serial_model (
   // serial port pins
   output logic portSelect_n,
   output logic portClk,
   output logic serial_data_in
);
   // ==========================================
   // idle levels follow the pin pulls: select up, clock and data down
   initial begin
      portSelect_n = 1'b1;
      portClk = 1'b0;
      serial_data_in = 1'b0;
   end
   // lsb first at 160 ns a bit; select moves only while the clock is low
   task automatic send(input logic [15:0] w, input int n);
      portSelect_n = 1'b0;
      #80;
      for (int i = 0; i < n; i++) begin
         serial_data_in = w[i];
         portClk = 1'b1;
         #80;
         portClk = 1'b0;
         #80;
      end
      portSelect_n = 1'b1;
      serial_data_in = 1'b0; // released line falls to its pull-down
   endtask
endmodule

/* tb/operating_mode_controller_test.sv */
// self-checking bench for the operating-mode controller
`timescale 1ns/1ns
`include "opmode_regs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module operating_mode_controller_test;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic linWakeDetect = 1'b0, linBusRx = 1'b1, monPin = 1'b0, ldoCurrentLow = 1'b0;
   logic wdExpired = 1'b0;
   logic [4:0] curMode;
   wire portSelect_n, portClk, serial_data_in;
   wire [`ST_W-1:0] modeState;
   wire busWakeFlag_q, regulatorEn_q, watchdogEn_q, oscKeepOn_q, wakePinEn_q, linTxEn_q;
   wire linRxEn_q, rxdOut_q, lowSide1En_q, lowSide2En_q, highSideLedEn_q, measEn_q;
   int mismatches = 0, checks = 0, cycles = 0;
   // ==========================================
   // clock, design and partner
   always #10 core_clk = ~core_clk;
   operating_mode_controller operating_mode_controller_inst (.core_clk, .arst_n,
      .portSelect_n, .portClk, .serial_data_in, .linWakeDetect, .linBusRx, .monPin,
      .ldoCurrentLow, .wdExpired, .modeState, .linSleepMode_q(), .busWakeFlag_q,
      .deviceReset_q(), .wdLongOpen_q(), .regulatorEn_q, .watchdogEn_q, .oscKeepOn_q,
      .serialPortEn_q(), .wakePinEn_q, .supplyOutEn_q(), .lowSide1En_q, .lowSide2En_q,
      .highSideLedEn_q, .measEn_q, .vrefEn_q(), .voltMonEn_q(), .linTxEn_q, .linRxEn_q,
      .linPullupEn_q(), .linWakeArmed_q(), .rxdOut_q);
   mcu_serial_model partner_inst (.portSelect_n, .portClk, .serial_data_in);
   task automatic stop_test;
      if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // a hang is cut short well past the expected few thousand cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 10000) begin
         mismatches++;
         stop_test();
      end
   end
   // words are ignored in sleep; unassigned codes keep the mode
   function automatic logic [4:0] nextMode(input logic [2:0] c, input logic [4:0] cur);
      if (cur == `ST_SLEEP) return cur;
      case (c)
         `MS_ACTIVE: return `ST_ACTIVE;
         `MS_RXONLY: return `ST_RXONLY;
         `MS_STOP: return `ST_STOP;
         `MS_SLEEP: return `ST_SLEEP;
         default: return cur;
      endcase
   endfunction
   // random upper fields; lin-sleep and watchdog bits only when asked for
   task automatic cmd(input logic [2:0] m, input logic [15:0] setBits);
      logic [15:0] w;
      w = (16'($urandom) & 16'hffe0) | setBits | {13'h0000, m};
      partner_inst.send(w, 16);
      repeat (12) @(negedge core_clk);
      curMode = nextMode(m, curMode);
      `CHK(modeState, curMode)
      if (curMode == `ST_ACTIVE)
         `CHK({measEn_q, highSideLedEn_q, lowSide2En_q, lowSide1En_q}, w[10:7])
   endtask
   task automatic linWake;
      linWakeDetect = 1'b1;
      repeat (6) @(negedge core_clk);
      linWakeDetect = 1'b0;
      repeat (4) @(negedge core_clk);
      `CHK(rxdOut_q, 1'b0)
   endtask
   initial begin
      void'($urandom(86));
      repeat (4) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      curMode = `ST_STANDBY;
      `CHK({modeState, regulatorEn_q, wakePinEn_q}, {`ST_STANDBY, 2'b10})
      cmd(3'h0, 16'h0000);
      cmd(`MS_ACTIVE, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         linBusRx = 1'($urandom);
         repeat (6) @(negedge core_clk);
         `CHK(rxdOut_q, linBusRx)
      end
      cmd(`MS_RXONLY, 16'h0000);
      `CHK({linTxEn_q, linRxEn_q}, 2'b01)
      for (int c = 5; c < 8; c++) cmd(3'(c), 16'h0000);
      cmd(`MS_STOP, 16'h0010);
      ldoCurrentLow = 1'b1;
      repeat (8) @(negedge core_clk);
      `CHK(watchdogEn_q, 1'b0)
      ldoCurrentLow = 1'b0;
      linWake();
      curMode = `ST_STANDBY;
      `CHK(modeState, curMode)
      cmd(`MS_SLEEP, 16'h0010);
      `CHK({regulatorEn_q, oscKeepOn_q}, 2'b01)
      wdExpired = 1'b1;
      @(negedge core_clk);
      wdExpired = 1'b0;
      repeat (3) @(negedge core_clk);
      curMode = `ST_STANDBY;
      `CHK(modeState, curMode)
      cmd(`MS_SLEEP, 16'h0000);
      `CHK(watchdogEn_q, 1'b0)
      cmd(`MS_ACTIVE, 16'h0000);
      linWake();
      curMode = `ST_STANDBY;
      `CHK({modeState, busWakeFlag_q}, {`ST_STANDBY, 1'b1})
      cmd(`MS_ACTIVE, 16'h0020);
      cmd(`MS_ACTIVE, 16'h0028);
      `CHK({linTxEn_q, linRxEn_q}, 2'b00)
      linWake();
      `CHK({busWakeFlag_q, linTxEn_q}, 2'b10)
      cmd(`MS_ACTIVE, 16'h0020);
      `CHK(linTxEn_q, 1'b1)
      cmd(`MS_SLEEP, 16'h0020);
      monPin = 1'b1;
      repeat (8) @(negedge core_clk);
      curMode = `ST_STANDBY;
      `CHK(modeState, curMode)
      partner_inst.send(16'h0001, 15);
      repeat (12) @(negedge core_clk);
      `CHK(modeState, curMode)
      stop_test();
   end
endmodule
